// *** src/alarm_mask_and_lane_fault.sv ***
// Alarm aggregation: six sticky faults, mask, summary alarm,
// per-lane FIFO fault flags, alarm pin select and interrupt.
// Assumes fault and lane inputs come from logic on core_clk_i.
`timescale 1ns/1ps
module alarm_mask_and_lane_fault
  import alarm_pkg::*;
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire reg_req_t             reg_req_i,
  output logic [DATA_W-1:0]         rd_data_o,
  input  wire fault_vec_t           fault_cond_i,
  input  wire logic [NUM_LANES-1:0] lane_fault_i,
  input  wire logic [NUM_LANES-1:0] lane_active_i,
  output logic                      alarm_o,
  output logic                      status_out_pin_o,
  output logic                      irq_o
);

  // State
  logic [7:0]           fault_mask;
  logic [5:0]           fault_status;
  logic [NUM_LANES-1:0] lane_fifo_fault_flags;
  logic                 pin_sel;
  logic [5:0]           irq_status;
  logic [5:0]           irq_mask;
  logic [DATA_W-1:0]    rd_data;

  logic [7:0]           next_fault_mask;
  logic [5:0]           next_fault_status;
  logic [NUM_LANES-1:0] next_lane_flags;
  logic                 next_pin_sel;
  logic [5:0]           next_irq_status;
  logic [5:0]           next_irq_mask;
  logic [DATA_W-1:0]    next_rd_data;

  logic [5:0]           flt_set;
  logic [5:0]           unmasked;
  logic                 summary;

  // Write strobe decode for one offset
  function automatic logic wr_hit(input reg_req_t r,
                                  input logic [9:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  function automatic logic rd_hit(input reg_req_t r,
                                  input logic [9:0] a);
    rd_hit = r.rd && (r.addr == a);
  endfunction : rd_hit

  // Hardware set terms for the six faults
  always_comb begin
    flt_set = fault_cond_i;
    flt_set[FLT_LANE] = fault_cond_i.lane_fifo_fault
                      | (|(lane_fault_i & lane_active_i));
  end

  // Each of mask bits 5:0 keeps its fault out of the summary
  always_comb begin
    unmasked = 6'h00;
    unmasked[FLT_LANE] = fault_status[FLT_LANE]
                       & ~fault_mask[FLT_LANE];
    unmasked[FLT_LOCK] = fault_status[FLT_LOCK]
                       & ~fault_mask[FLT_LOCK];
    unmasked[FLT_LINK] = fault_status[FLT_LINK]
                       & ~fault_mask[FLT_LINK];
    unmasked[FLT_ALGN] = fault_status[FLT_ALGN]
                       & ~fault_mask[FLT_ALGN];
    unmasked[FLT_OSC]  = fault_status[FLT_OSC]
                       & ~fault_mask[FLT_OSC];
    unmasked[FLT_DIV]  = fault_status[FLT_DIV]
                       & ~fault_mask[FLT_DIV];
    summary = |unmasked;
  end

  // Outputs come straight from register state
  assign alarm_o          = summary;
  assign status_out_pin_o = pin_sel & summary;
  assign irq_o            = |(irq_status & ~irq_mask);
  assign rd_data_o        = rd_data;

  // Next register values; hardware sets win over clears
  always_comb begin
    next_fault_mask   = fault_mask;
    next_pin_sel      = pin_sel;
    next_irq_mask     = irq_mask;
    next_fault_status = fault_status;
    next_lane_flags   = lane_fifo_fault_flags;
    next_irq_status   = irq_status;
    if (wr_hit(reg_req_i, ADDR_MASK)) begin
      next_fault_mask = reg_req_i.wdata[7:0];
    end
    if (wr_hit(reg_req_i, ADDR_PIN_SEL)) begin
      next_pin_sel = reg_req_i.wdata[PIN_SEL_BIT];
    end
    if (wr_hit(reg_req_i, ADDR_IRQ_MASK)) begin
      next_irq_mask = reg_req_i.wdata[5:0];
    end
    // Sticky fault flags, write one to clear
    if (wr_hit(reg_req_i, ADDR_STATUS)) begin
      next_fault_status = fault_status
                        & ~reg_req_i.wdata[5:0];
    end
    next_fault_status = next_fault_status | flt_set;
    // Lane flags: clear by one, fault sets last
    if (wr_hit(reg_req_i, ADDR_LANE)) begin
      next_lane_flags = lane_fifo_fault_flags
                      & ~reg_req_i.wdata;
    end
    // Set after clear so a live fault re-trips
    next_lane_flags = next_lane_flags
                    | lane_fault_i;
    // Interrupt status clears on read; an event still wins
    if (rd_hit(reg_req_i, ADDR_IRQ_STAT)) begin
      next_irq_status = 6'h00;
    end
    next_irq_status = next_irq_status | flt_set;
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    next_rd_data = '0;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        ADDR_SUMMARY:  next_rd_data = {15'h0000, summary};
        ADDR_STATUS:   next_rd_data = {10'h000, fault_status};
        ADDR_MASK:     next_rd_data = {8'h00, fault_mask};
        ADDR_LANE:     next_rd_data = lane_fifo_fault_flags;
        ADDR_PIN_SEL:  next_rd_data = {15'h0000, pin_sel};
        ADDR_IRQ_STAT: next_rd_data = {10'h000, irq_status};
        ADDR_IRQ_MASK: next_rd_data = {10'h000, irq_mask};
        default:       next_rd_data = '0;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_mask            <= MASK_RST;
      fault_status          <= STATUS_RST;
      lane_fifo_fault_flags <= LANE_RST;
      pin_sel               <= PIN_SEL_RST;
      irq_status            <= IRQ_STAT_RST;
      irq_mask              <= IRQ_MASK_RST;
      rd_data               <= '0;
    end else begin
      fault_mask            <= next_fault_mask;
      fault_status          <= next_fault_status;
      lane_fifo_fault_flags <= next_lane_flags;
      pin_sel               <= next_pin_sel;
      irq_status            <= next_irq_status;
      irq_mask              <= next_irq_mask;
      rd_data               <= next_rd_data;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Only one fault set, that one masked: no alarm
  lane_mask_a:
    assert property (fault_status == 6'h20 && fault_mask[FLT_LANE]
                     |-> !alarm_o)
    else $error("masked lane fault raised alarm");

  lock_mask_a:
    assert property (fault_status == 6'h10 && fault_mask[FLT_LOCK]
                     |-> !alarm_o)
    else $error("masked lock loss raised alarm");

  link_mask_a:
    assert property (fault_status == 6'h08 && fault_mask[FLT_LINK]
                     |-> !alarm_o)
    else $error("masked link fault raised alarm");

  realign_mask_a:
    assert property (fault_status == 6'h04 && fault_mask[FLT_ALGN]
                     |-> !alarm_o)
    else $error("masked realign fault raised alarm");

  phase_mask_a:
    assert property (fault_status == 6'h02 && fault_mask[FLT_OSC]
                     |-> !alarm_o)
    else $error("masked phase fault raised alarm");

  divider_mask_a:
    assert property (fault_status == 6'h01 && fault_mask[FLT_DIV]
                     |-> !alarm_o)
    else $error("masked divider fault raised alarm");

  // A fault unmasked now gives an alarm a cycle later
  summary_alarm_a:
    assert property ((|(flt_set & ~fault_mask[5:0]))
                     && !wr_hit(reg_req_i, ADDR_MASK)
                     |=> alarm_o)
    else $error("unmasked fault gave no alarm");

  // Every lane that faulted is flagged next cycle
  lane_set_a:
    assert property (1'b1 |=> ((lane_fifo_fault_flags
                     & $past(lane_fault_i)) == $past(lane_fault_i)))
    else $error("lane fault not recorded");

  // Write one clears only the written lanes
  lane_clear_a:
    assert property (wr_hit(reg_req_i, ADDR_LANE)
                     && lane_fault_i == 16'h0000
                     |=> lane_fifo_fault_flags ==
                         ($past(lane_fifo_fault_flags)
                          & ~$past(reg_req_i.wdata)))
    else $error("lane clear wrong");

  // A fault held through its own clear stays flagged
  lane_retrip_a:
    assert property (wr_hit(reg_req_i, ADDR_LANE)
                     && |(lane_fault_i & reg_req_i.wdata)
                     |=> (lane_fifo_fault_flags & $past(lane_fault_i)
                          & $past(reg_req_i.wdata))
                         == ($past(lane_fault_i)
                             & $past(reg_req_i.wdata)))
    else $error("persisting lane fault not re-flagged");

  // Active lane fault reaches the aggregate flag
  lane_agg_a:
    assert property (|(lane_fault_i & lane_active_i)
                     |=> fault_status[FLT_LANE])
    else $error("lane fault missed aggregate flag");

  // Status clear by write one, unless a set coincides
  status_w1c_a:
    assert property (wr_hit(reg_req_i, ADDR_STATUS)
                     && reg_req_i.wdata[5:0] == 6'h3F
                     && flt_set == 6'h00
                     |=> fault_status == 6'h00 && !alarm_o)
    else $error("status write one did not clear");

  // Mask write lands in all eight bits, spare ones too
  mask_write_a:
    assert property (wr_hit(reg_req_i, ADDR_MASK)
                     |=> fault_mask == $past(reg_req_i.wdata[7:0]))
    else $error("mask write lost");

  // Pin follows summary only while selected
  pin_follow_a:
    assert property (pin_sel |-> status_out_pin_o == alarm_o)
    else $error("pin not driving alarm");

  pin_quiet_a:
    assert property (!pin_sel |-> !status_out_pin_o)
    else $error("pin driven while not selected");

  // Read data only in the cycle after a read
  rd_idle_a:
    assert property (!reg_req_i.rd |=> rd_data_o == 16'h0000)
    else $error("read data without read");

  rd_lane_a:
    assert property (rd_hit(reg_req_i, ADDR_LANE)
                     |=> rd_data_o == $past(lane_fifo_fault_flags))
    else $error("lane read data wrong");

  // Flags hold unless their clear is written
  status_hold_a:
    assert property (!wr_hit(reg_req_i, ADDR_STATUS)
                     |=> (fault_status & $past(fault_status))
                         == $past(fault_status))
    else $error("fault flag dropped without clear");

  // Any fault set term lands, even beside a clear
  status_set_a:
    assert property (1'b1 |=> (fault_status & $past(flt_set))
                              == $past(flt_set))
    else $error("fault set term lost");

  // Lane flags stay until written with a one
  lane_hold_a:
    assert property (!wr_hit(reg_req_i, ADDR_LANE)
                     |=> (lane_fifo_fault_flags
                          & $past(lane_fifo_fault_flags))
                         == $past(lane_fifo_fault_flags))
    else $error("lane flag dropped without clear");

  // Summary offset reads back the alarm level
  summary_read_a:
    assert property (rd_hit(reg_req_i, ADDR_SUMMARY)
                     |=> rd_data_o == {15'h0000, $past(alarm_o)})
    else $error("summary read wrong");

  // Reading the interrupt status empties it if nothing new came
  irq_clear_a:
    assert property (rd_hit(reg_req_i, ADDR_IRQ_STAT)
                     && flt_set == 6'h00
                     |=> irq_status == 6'h00 && !irq_o)
    else $error("interrupt status not cleared by read");

  // Main scenarios
  lane_retrip_c:
    cover property (wr_hit(reg_req_i, ADDR_LANE) && |lane_fault_i);

  alarm_rise_c:
    cover property (!alarm_o ##1 alarm_o);

  irq_rise_c:
    cover property (!irq_o ##1 irq_o ##[1:8] !irq_o);

  lane_clash_c:
    cover property (wr_hit(reg_req_i, ADDR_LANE)
                    && |(lane_fault_i & reg_req_i.wdata));

  pin_alarm_c:
    cover property (status_out_pin_o);

endmodule : alarm_mask_and_lane_fault

// *** src/alarm_pkg.sv ***
// Constants and types for the alarm mask and lane fault block.
// Assumes one core clock and a plain register port on that clock.
//
// What this block does
// - Lane FIFO mask blocks lane fault from alarm
// - Lock loss mask blocks lock loss fault
// - Link state mask blocks link fault
// - Realign mask blocks realign fault
// - Oscillator phase mask blocks phase fault
// - Divider mask blocks divider mismatch fault
// - Mask resets all six set, top zero
// - Lane fault sets that lane's flag
// - Writing one clears lane flag bit
// - Persisting lane fault sets flag again
// - All sixteen lane flags set after reset
// - Summary alarm is any unmasked fault flag
// - Six fault flags sticky, W1C, reset set
// - Any active lane fault sets lane flag
// - Select drives summary alarm onto pin
package alarm_pkg;

  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 16;
  localparam int NUM_FLT   = 6;
  localparam int NUM_LANES = 16;

  // Register offsets
  localparam logic [9:0] ADDR_SUMMARY  = 10'h2C0;
  localparam logic [9:0] ADDR_STATUS   = 10'h2C1;
  localparam logic [9:0] ADDR_MASK     = 10'h2C2;
  localparam logic [9:0] ADDR_LANE     = 10'h2C4;
  localparam logic [9:0] ADDR_PIN_SEL  = 10'h2C5;
  localparam logic [9:0] ADDR_IRQ_STAT = 10'h2C6;
  localparam logic [9:0] ADDR_IRQ_MASK = 10'h2C7;

  // Field positions inside status and mask
  localparam int FLT_LANE = 5;
  localparam int FLT_LOCK = 4;
  localparam int FLT_LINK = 3;
  localparam int FLT_ALGN = 2;
  localparam int FLT_OSC  = 1;
  localparam int FLT_DIV  = 0;
  localparam int PIN_SEL_BIT = 0;

  // Reset values
  localparam logic [7:0]  MASK_RST     = 8'h3F;
  localparam logic [5:0]  STATUS_RST   = 6'h3F;
  localparam logic [15:0] LANE_RST     = 16'hFFFF;
  localparam logic [5:0]  IRQ_MASK_RST = 6'h3F;
  localparam logic [5:0]  IRQ_STAT_RST = 6'h00;
  localparam logic        PIN_SEL_RST  = 1'h0;

  typedef struct packed {
    logic lane_fifo_fault;
    logic lock_loss_fault;
    logic link_state_fault;
    logic realign_fault;
    logic osc_phase_fault;
    logic divider_mismatch_fault;
  } fault_vec_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : alarm_pkg

// *** test/alarm_mask_and_lane_fault_bench.sv ***
// Self-checking bench for the alarm mask and lane fault block.
// Assumes the register port and fault inputs all run on core_clk_i.
`timescale 1ns/1ps
module alarm_mask_and_lane_fault_bench;
  import alarm_pkg::*;

  logic                 core_clk_i;
  logic                 rst_n_i;
  reg_req_t             req;
  logic [DATA_W-1:0]    rd_data_o;
  fault_vec_t           fault_cond_i;
  logic [NUM_LANES-1:0] lane_fault_i;
  logic [NUM_LANES-1:0] lane_active_i;
  logic                 alarm_o;
  logic                 status_out_pin_o;
  logic                 irq_o;
  int                   miscompares;
  int                   checks_done;
  logic [15:0]          d;

  alarm_mask_and_lane_fault i_alarm_mask_and_lane_fault (
    .core_clk_i      (core_clk_i),
    .rst_n_i         (rst_n_i),
    .reg_req_i       (req),
    .rd_data_o       (rd_data_o),
    .fault_cond_i    (fault_cond_i),
    .lane_fault_i    (lane_fault_i),
    .lane_active_i   (lane_active_i),
    .alarm_o         (alarm_o),
    .status_out_pin_o(status_out_pin_o),
    .irq_o           (irq_o)
  );

  // Free running 100 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Register values and pin levels are compared separately
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t register got %h want %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t pin got %b want %b", $time, got, exp);
    end
  endtask : chk1

  // One-cycle write strobe; returns mid-cycle with outputs settled
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req.wr <= 1'b0;
    @(negedge core_clk_i);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, output logic [15:0] v);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    @(negedge core_clk_i);
    v = rd_data_o;
  endtask : rd

  // Fault levels held for exactly one sampling edge
  task automatic pulse(input fault_vec_t f, input logic [15:0] l);
    @(posedge core_clk_i);
    fault_cond_i <= f;
    lane_fault_i <= l;
    @(posedge core_clk_i);
    fault_cond_i <= '0;
    lane_fault_i <= 16'h0000;
    @(negedge core_clk_i);
  endtask : pulse

  // Hang guard: whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    miscompares = 0;
    checks_done = 0;
    rst_n_i = 1'b0;
    req = '0;
    fault_cond_i = '0;
    lane_fault_i = 16'h0000;
    lane_active_i = 16'h0000;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    // Reset state and unmapped hole
    rd(ADDR_MASK, d);   chk16(d, 16'h003F);
    rd(ADDR_STATUS, d); chk16(d, 16'h003F);
    rd(ADDR_LANE, d);   chk16(d, 16'hFFFF);
    chk1(alarm_o, 1'b0);
    wr(10'h2C3, 16'hFFFF);
    rd(10'h2C3, d);     chk16(d, 16'h0000);
    // Lane flags clear only where a one is written
    wr(ADDR_LANE, 16'h00FF);
    rd(ADDR_LANE, d);   chk16(d, 16'hFF00);
    wr(ADDR_LANE, 16'hFF00);
    wr(ADDR_STATUS, 16'h003F);
    rd(ADDR_STATUS, d); chk16(d, 16'h0000);
    // Inactive lane marks its own flag but not the aggregate
    pulse('0, 16'h0008);
    rd(ADDR_LANE, d);   chk16(d, 16'h0008);
    rd(ADDR_STATUS, d); chk16(d, 16'h0000);
    @(posedge core_clk_i);
    lane_active_i <= 16'hFFFF;
    pulse('0, 16'h0008);
    rd(ADDR_STATUS, d); chk16(d, 16'h0020);
    // Persisting fault trips again after the clear
    @(posedge core_clk_i);
    lane_fault_i <= 16'h0080;
    wr(ADDR_LANE, 16'h0088);
    @(posedge core_clk_i);
    lane_fault_i <= 16'h0000;
    rd(ADDR_LANE, d);   chk16(d, 16'h0080);
    // Event and clear landing on the same edge: set wins
    @(posedge core_clk_i);
    req <= '{addr: ADDR_LANE, wdata: 16'h0280, wr: 1'b1, rd: 1'b0};
    lane_fault_i <= 16'h0200;
    @(posedge core_clk_i);
    req.wr <= 1'b0;
    lane_fault_i <= 16'h0000;
    rd(ADDR_LANE, d);   chk16(d, 16'h0200);
    wr(ADDR_LANE, 16'hFFFF);
    wr(ADDR_IRQ_MASK, 16'h0000);
    // Each fault masked alone, then unmasked; pin and interrupt
    for (int i = 0; i < NUM_FLT; i++) begin
      wr(ADDR_MASK, 16'h0001 << i);
      wr(ADDR_STATUS, 16'h003F);
      rd(ADDR_IRQ_STAT, d);
      pulse(fault_vec_t'(6'h01 << i), 16'h0000);
      chk1(alarm_o, 1'b0);
      chk1(irq_o, 1'b1);
      rd(ADDR_IRQ_STAT, d); chk16(d, 16'h0001 << i);
      chk1(irq_o, 1'b0);
      wr(ADDR_MASK, 16'h003F & ~(16'h0001 << i));
      chk1(alarm_o, 1'b1);
      rd(ADDR_SUMMARY, d); chk16(d, 16'h0001);
      rd(ADDR_STATUS, d);  chk16(d, 16'h0001 << i);
      chk1(status_out_pin_o, 1'b0);
      wr(ADDR_PIN_SEL, 16'h0001);
      chk1(status_out_pin_o, 1'b1);
      wr(ADDR_PIN_SEL, 16'h0000);
      wr(ADDR_STATUS, 16'h0001 << i);
      chk1(alarm_o, 1'b0);
    end
    // Masked interrupt stays low
    wr(ADDR_IRQ_MASK, 16'h003F);
    pulse(fault_vec_t'(6'h10), 16'h0000);
    chk1(irq_o, 1'b0);
    tally_and_finish();
  end
endmodule : alarm_mask_and_lane_fault_bench
